/* gpr_defs.vh */
// Offsets, field limits and reset values of the three-port register block
`ifndef GPR_DEFS_VH
`define GPR_DEFS_VH
// Distance between data-space and I/O-space addresses
`define GPR_IO_OFFSET 8'h20
// Highest I/O-space address
`define GPR_IO_MAX 8'h3f
// Data-space offsets
`define GPR_PORT_B_PIN_INPUT 8'h23
`define GPR_PORT_B_DIRECTION 8'h24
`define GPR_PORT_B_OUTPUT_DATA 8'h25
`define GPR_PORT_C_PIN_INPUT 8'h26
`define GPR_PORT_C_DIRECTION 8'h27
`define GPR_PORT_C_OUTPUT_DATA 8'h28
`define GPR_PORT_D_PIN_INPUT 8'h29
`define GPR_PORT_D_DIRECTION 8'h2a
`define GPR_PORT_D_OUTPUT_DATA 8'h2b
// Reset value of data and direction registers
`define GPR_RESET_VALUE 8'h00
// Implemented bits per port
`define GPR_MASK_B 8'hff
`define GPR_MASK_C 8'h7f
`define GPR_MASK_D 8'hff
`endif

/* gpr_port.v */
// One eight-bit port: data, direction, toggle, pull-up and pin drive
`timescale 1ns/1ns
`include "gpr_defs.vh"
module gpr_port #(
  parameter [7:0] MASK = 8'hff
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register writes, one cycle pulses
  input wire wr_data,
  input wire wr_dir,
  input wire wr_pin,
  input wire [7:0] wdata,
  // Global pull-up disable
  input wire global_pullup_disable,
  // Pin side
  input wire [7:0] pin_in,
  output wire [7:0] pin_out,
  output wire [7:0] pin_oe_n,
  output wire [7:0] pullup_en,
  // Register contents
  output reg [7:0] output_data,
  output reg [7:0] direction,
  output reg [7:0] pin_sample
);
  // Next output data value
  reg [7:0] next_output_data;

  // Write or toggle select for output data
  always @* begin
    next_output_data = output_data;
    if (wr_data) begin
      next_output_data = wdata & MASK;
    end else if (wr_pin) begin
      // R6: toggle instead of store
      // R14: ones invert, zeros keep
      next_output_data = (output_data ^ wdata) & MASK;
    end
  end

  // Data and direction registers
  always @(posedge clk) begin
    if (srst) begin
      // R3: zero at reset
      output_data <= `GPR_RESET_VALUE;
      direction <= `GPR_RESET_VALUE;
    end else begin
      output_data <= next_output_data;
      if (wr_dir) begin
        direction <= wdata & MASK;
      end
    end
  end

  // R5: pin levels sampled, no reset
  always @(posedge clk) begin
    pin_sample <= pin_in & MASK;
  end

  // Per-bit pin drive and pull-up
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      // R15: drive when direction set
      assign pin_out[i] = output_data[i] & direction[i];
      assign pin_oe_n[i] = ~direction[i];
      // R13: pull-up on input with data one
      assign pullup_en[i] = ~direction[i] & output_data[i] & ~global_pullup_disable;
    end
  endgenerate
endmodule // gpr_port

/* gpr_top.v */
// Register block for three I/O ports with data and I/O space decode
`timescale 1ns/1ns
`include "gpr_defs.vh"
// Behaviour
// R1: decode data offset and offset minus 0x20
// R2: software uses full offset for loads
// R3: port B data 0x25, resets zero
// R4: port B direction 0x24, resets zero
// R5: port B pins 0x23, sampled levels
// R6: pin-input write toggles outputs
// R7: port C data 0x28, bits 6:0
// R8: port C direction 0x27, bits 6:0
// R9: port C pins 0x26, bits 6:0
// R10: port D data 0x2B, resets zero
// R11: port D direction 0x2A, resets zero
// R12: port D pins 0x29, sampled levels
// R13: pull-up when input, data one, enabled
// R14: one inverts bit, zero keeps
// R15: direction one drives data onto pin
module gpr_top (
  // Clock and reset
  input wire CLK,
  input wire SRST,
  // Register access port
  input wire [7:0] ADDR,
  input wire IO_SPACE,
  input wire WR,
  input wire RD,
  input wire [7:0] WDATA,
  output reg [7:0] RDATA,
  output reg HIT,
  // Global pull-up disable level
  input wire GLOBAL_PULLUP_DISABLE,
  // Port B pins
  input wire [7:0] PB_IN,
  output wire [7:0] PB_OUT,
  output wire [7:0] PB_OE_N,
  output wire [7:0] PB_PULLUP,
  // Port C pins
  input wire [7:0] PC_IN,
  output wire [7:0] PC_OUT,
  output wire [7:0] PC_OE_N,
  output wire [7:0] PC_PULLUP,
  // Port D pins
  input wire [7:0] PD_IN,
  output wire [7:0] PD_OUT,
  output wire [7:0] PD_OE_N,
  output wire [7:0] PD_PULLUP
);
  // One set of registers answers two address spaces.
  // I/O space is the compact window reached by the short instructions;
  // its addresses are the data offsets less a fixed distance.
  // Data space is reached by loads and stores at the full offset, so a
  // store to a small I/O number lands on no register here.
  // Reads are answered from flops one cycle after the strobe, which
  // puts pin reads two edges behind the pads.
  // Pin-input writes never store; each set bit flips an output data bit.
  // Port C has no bit 7: it reads zero, never drives, never pulls up.

  // Data-space address after I/O translation
  reg [7:0] dspace;
  // Address lies in a legal window
  reg addr_ok;
  // I/O address inside the low window
  wire io_in_range;
  // I/O address moved up into data space
  wire [7:0] io_shifted;

  // Register selects, valid in either space
  wire sel_b_pin;
  wire sel_b_dir;
  wire sel_b_data;
  wire sel_c_pin;
  wire sel_c_dir;
  wire sel_c_data;
  wire sel_d_pin;
  wire sel_d_dir;
  wire sel_d_data;
  // Some register of the nine is selected
  wire any_sel;

  // Per-port write strobes, index 0 is port B
  wire [2:0] wr_pin;
  wire [2:0] wr_dir;
  wire [2:0] wr_data;

  // Port B register contents
  wire [7:0] b_data;
  wire [7:0] b_dir;
  wire [7:0] b_pin;
  // Port C register contents
  wire [7:0] c_data;
  wire [7:0] c_dir;
  wire [7:0] c_pin;
  // Port D register contents
  wire [7:0] d_data;
  wire [7:0] d_dir;
  wire [7:0] d_pin;

  // Read value before the output flop
  reg [7:0] next_rdata;
  // Read hit before the output flop
  reg next_hit;

  // R1: I/O window is 0x00 to 0x3f only
  assign io_in_range = (ADDR <= `GPR_IO_MAX);
  // R1: I/O addresses sit 0x20 below data offsets
  // The sum wraps for large addresses, but those fail the window check
  assign io_shifted = ADDR + `GPR_IO_OFFSET;

  // R1: choose the space for this access
  always @* begin
    if (IO_SPACE) begin
      // Short instructions, translated address
      addr_ok = io_in_range;
      dspace = io_shifted;
    end else begin
      // Loads and stores use the full offset
      addr_ok = 1'b1;
      dspace = ADDR;
    end
  end

  // R1: register selects on the data-space address
  // Port B selects
  // Pin-input, toggles on write
  assign sel_b_pin = addr_ok & (dspace == `GPR_PORT_B_PIN_INPUT);
  // Direction
  assign sel_b_dir = addr_ok & (dspace == `GPR_PORT_B_DIRECTION);
  // Output data
  assign sel_b_data = addr_ok & (dspace == `GPR_PORT_B_OUTPUT_DATA);

  // Port C selects
  // Pin-input, toggles on write
  assign sel_c_pin = addr_ok & (dspace == `GPR_PORT_C_PIN_INPUT);
  // Direction
  assign sel_c_dir = addr_ok & (dspace == `GPR_PORT_C_DIRECTION);
  // Output data
  assign sel_c_data = addr_ok & (dspace == `GPR_PORT_C_OUTPUT_DATA);

  // Port D selects
  // Pin-input, toggles on write
  assign sel_d_pin = addr_ok & (dspace == `GPR_PORT_D_PIN_INPUT);
  // Direction
  assign sel_d_dir = addr_ok & (dspace == `GPR_PORT_D_DIRECTION);
  // Output data
  assign sel_d_data = addr_ok & (dspace == `GPR_PORT_D_OUTPUT_DATA);

  // Any mapped register
  assign any_sel = sel_b_pin | sel_b_dir | sel_b_data | sel_c_pin | sel_c_dir | sel_c_data |
    sel_d_pin | sel_d_dir | sel_d_data;

  // R1: write strobes, one register per access
  // Port B strobes
  assign wr_pin[0] = WR & sel_b_pin;
  assign wr_dir[0] = WR & sel_b_dir;
  assign wr_data[0] = WR & sel_b_data;
  // Port C strobes
  assign wr_pin[1] = WR & sel_c_pin;
  assign wr_dir[1] = WR & sel_c_dir;
  assign wr_data[1] = WR & sel_c_data;
  // Port D strobes
  assign wr_pin[2] = WR & sel_d_pin;
  assign wr_dir[2] = WR & sel_d_dir;
  assign wr_data[2] = WR & sel_d_data;

  // R3: R4: R5: port B, eight bits
  // All eight pins usable
  gpr_port #(
    .MASK(`GPR_MASK_B)
  ) u_port_b (
    // Clock and reset
    .clk(CLK),
    .srst(SRST),
    // Write strobes and data
    .wr_data(wr_data[0]),
    .wr_dir(wr_dir[0]),
    .wr_pin(wr_pin[0]),
    .wdata(WDATA),
    // Pull-up kill
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    // Pins
    .pin_in(PB_IN),
    .pin_out(PB_OUT),
    .pin_oe_n(PB_OE_N),
    .pullup_en(PB_PULLUP),
    // Register contents for reads
    .output_data(b_data),
    .direction(b_dir),
    .pin_sample(b_pin)
  );

  // R7: R8: R9: port C, bit 7 absent
  // The mask keeps bit 7 at zero in every register
  gpr_port #(
    .MASK(`GPR_MASK_C)
  ) u_port_c (
    // Clock and reset
    .clk(CLK),
    .srst(SRST),
    // Write strobes and data
    .wr_data(wr_data[1]),
    .wr_dir(wr_dir[1]),
    .wr_pin(wr_pin[1]),
    .wdata(WDATA),
    // Pull-up kill
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    // Pins
    .pin_in(PC_IN),
    .pin_out(PC_OUT),
    .pin_oe_n(PC_OE_N),
    .pullup_en(PC_PULLUP),
    // Register contents for reads
    .output_data(c_data),
    .direction(c_dir),
    .pin_sample(c_pin)
  );

  // R10: R11: R12: port D, eight bits
  // All eight pins usable
  gpr_port #(
    .MASK(`GPR_MASK_D)
  ) u_port_d (
    // Clock and reset
    .clk(CLK),
    .srst(SRST),
    // Write strobes and data
    .wr_data(wr_data[2]),
    .wr_dir(wr_dir[2]),
    .wr_pin(wr_pin[2]),
    .wdata(WDATA),
    // Pull-up kill
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    // Pins
    .pin_in(PD_IN),
    .pin_out(PD_OUT),
    .pin_oe_n(PD_OE_N),
    .pullup_en(PD_PULLUP),
    // Register contents for reads
    .output_data(d_data),
    .direction(d_dir),
    .pin_sample(d_pin)
  );

  // R1: read multiplexer, zero when nothing is selected
  always @* begin
    next_rdata = 8'h00;
    next_hit = RD & any_sel;
    // Same map as the writes, so reads and writes never disagree
    if (RD & any_sel) begin
      case (dspace)
        // Port B
        `GPR_PORT_B_PIN_INPUT: begin
          next_rdata = b_pin;
        end
        `GPR_PORT_B_DIRECTION: begin
          next_rdata = b_dir;
        end
        `GPR_PORT_B_OUTPUT_DATA: begin
          next_rdata = b_data;
        end
        // Port C
        `GPR_PORT_C_PIN_INPUT: begin
          next_rdata = c_pin;
        end
        `GPR_PORT_C_DIRECTION: begin
          next_rdata = c_dir;
        end
        `GPR_PORT_C_OUTPUT_DATA: begin
          next_rdata = c_data;
        end
        // Port D
        `GPR_PORT_D_PIN_INPUT: begin
          next_rdata = d_pin;
        end
        `GPR_PORT_D_DIRECTION: begin
          next_rdata = d_dir;
        end
        `GPR_PORT_D_OUTPUT_DATA: begin
          next_rdata = d_data;
        end
        // Unmapped address, cannot occur with any_sel high
        default: begin
          next_hit = 1'b0;
        end
      endcase
    end
  end

  // Registered read answer, one cycle after the strobe
  // Flops keep RDATA steady while the address moves
  always @(posedge CLK) begin
    if (SRST) begin
      // Nothing to answer after reset
      RDATA <= 8'h00;
      HIT <= 1'b0;
    end else begin
      // Reloaded every edge, so it stands one cycle
      RDATA <= next_rdata;
      HIT <= next_hit;
    end
  end
endmodule // gpr_top

/* gpr_sva.sv */
// Assertions on pin controls and register reads of the three-port block
`timescale 1ns/1ns
module gpr_sva (
  // Clock, reset and register access
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic IO_SPACE,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic HIT,
  input wire logic GLOBAL_PULLUP_DISABLE,
  // Pin controls
  input wire logic [7:0] PB_OUT,
  input wire logic [7:0] PB_OE_N,
  input wire logic [7:0] PB_PULLUP,
  input wire logic [7:0] PC_OE_N,
  input wire logic [7:0] PC_PULLUP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // One of the nine offsets in the chosen space
  wire logic hit_addr = IO_SPACE ? ADDR inside {[8'h03:8'h0b]} : ADDR inside {[8'h23:8'h2b]};
  sequence map_rd; RD && hit_addr; endsequence
  sequence dir_b_wr; WR && !IO_SPACE && ADDR == 8'h24; endsequence
  sequence tgl_b_wr; WR && IO_SPACE && ADDR == 8'h03; endsequence
  read_hit_a: assert property (map_rd |=> HIT)
    else $error("no hit");
  read_miss_a: assert property (!(RD && hit_addr) |=> !HIT && RDATA == 8'h00)
    else $error("stray read data");
  dir_write_a: assert property (dir_b_wr |=> PB_OE_N == ~$past(WDATA))
    else $error("direction not written");
  pin_toggle_a: assert property (tgl_b_wr |=> PB_OUT == ($past(PB_OUT) ^ ($past(WDATA) & ~PB_OE_N)))
    else $error("toggle wrong");
  pull_off_a: assert property (GLOBAL_PULLUP_DISABLE |-> (PB_PULLUP | PC_PULLUP) == 8'h00)
    else $error("pull-up not disabled");
  pull_drive_a: assert property ((PB_PULLUP & ~PB_OE_N) == 8'h00)
    else $error("pull-up on driven pin");
  drive_only_a: assert property ((PB_OUT & PB_OE_N) == 8'h00)
    else $error("output on input pin");
  c_top_bit_a: assert property (PC_OE_N[7] && !PC_PULLUP[7])
    else $error("port C bit 7 active");
  reset_clear_a: assert property (disable iff (1'b0) SRST |=> PB_OE_N == 8'hff && PB_PULLUP == 8'h00)
    else $error("reset missed");
endmodule // gpr_sva
bind gpr_top gpr_sva chk (.*);

/* gpr_pins.sv */
// Pad model for one port: device drive, board drive, pull-up, float
`timescale 1ns/1ns
module gpr_pins (
  // Clock
  input wire logic clk,
  // Device side
  input wire logic [7:0] out,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] pu,
  // Board side
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  // Pad levels
  output wire logic [7:0] lvl
);
  logic [7:0] drift = 8'h5a; // Undriven pads wander
  // Float pattern flips every cycle
  always @(posedge clk) begin
    drift <= ~drift;
  end
  // device drive, then board, then pull-up
  assign lvl = ~oe_n & out | oe_n & (ext_en & ext | ~ext_en & (pu | drift));
endmodule // gpr_pins

/* testbench.sv */
// Self-checking bench for the three-port register block
`timescale 1ns/1ns
module testbench;
  // Design ports, same names so they connect by name
  logic CLK = 0, SRST = 1, IO_SPACE = 0, WR = 0, RD = 0, HIT, GLOBAL_PULLUP_DISABLE = 0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
  wire [7:0] PB_IN, PB_OUT, PB_OE_N, PB_PULLUP, PC_IN, PC_OUT, PC_OE_N, PC_PULLUP;
  wire [7:0] PD_IN, PD_OUT, PD_OE_N, PD_PULLUP;
  logic [7:0] bx = 8'h00, bx_en = 8'h00, dx = 8'h00, dx_en = 8'h00; // Board drive
  int n_fail = 0, comparisons = 0;
  // Rows: write addr, space, data; read addr, space, expected
  logic [47:0] rows [10] = '{48'h2500a50501a5, 48'h24003c04013c, 48'h2800ff08017f, 48'h2700ff27007f,
    48'h2b00960b0196, 48'h0a010f2a000f, 48'h0301ff25005a, 48'h06010128007e, 48'h290000_0b0196,
    48'h0500ff25005a};
  always #5 CLK = ~CLK;
  gpr_top dut (.*);
  gpr_pins pb_m (.clk(CLK), .out(PB_OUT), .oe_n(PB_OE_N), .pu(PB_PULLUP), .ext(bx), .ext_en(bx_en), .lvl(PB_IN));
  gpr_pins pc_m (.clk(CLK), .out(PC_OUT), .oe_n(PC_OE_N), .pu(PC_PULLUP), .ext(8'h00), .ext_en(8'h00), .lvl(PC_IN));
  gpr_pins pd_m (.clk(CLK), .out(PD_OUT), .oe_n(PD_OE_N), .pu(PD_PULLUP), .ext(dx), .ext_en(dx_en), .lvl(PD_IN));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] io, input logic [7:0] d);
    @(posedge CLK);
    {ADDR, IO_SPACE, WDATA, WR} <= {a, io[0], d, 1'b1};
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] io, input logic [7:0] exp, input logic h);
    @(posedge CLK);
    {ADDR, IO_SPACE, RD} <= {a, io[0], 1'b1};
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("read data", RDATA, exp);
    chk("hit", {7'h00, HIT}, {7'h00, h});
  endtask
  task automatic tally_and_finish;
    $display("TB: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog on the whole run
  initial begin
    #100000 n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][47:40], rows[i][39:32], rows[i][31:24]);
      rd(rows[i][23:16], rows[i][15:8], rows[i][7:0], 1'b1);
    end
    $display("TB: register rows done");
    rd(8'h45, 8'h01, 8'h00, 1'b0);
    rd(8'h05, 8'h00, 8'h00, 1'b0);
    @(posedge CLK) {bx, bx_en, dx, dx_en} <= {8'hc3, 8'hc3, 8'ha0, 8'hf0};
    rd(8'h03, 8'h01, 8'hdb, 1'b1);
    rd(8'h26, 8'h00, 8'h7e, 1'b1);
    rd(8'h29, 8'h00, 8'ha6, 1'b1);
    chk("b pull-up", PB_PULLUP, 8'h42);
    chk("d pull-up", PD_PULLUP, 8'h90);
    @(posedge CLK) GLOBAL_PULLUP_DISABLE <= 1'b1;
    #1 chk("d pull-up off", PD_PULLUP, 8'h00);
    @(posedge CLK) GLOBAL_PULLUP_DISABLE <= 1'b0;
    $display("TB: pins and pull-ups done");
    @(posedge CLK) SRST <= 1'b1;
    @(posedge CLK) SRST <= 1'b0;
    #1 chk("b drive enables", PB_OE_N, 8'hff);
    chk("d output", PD_OUT, 8'h00);
    rd(8'h25, 8'h00, 8'h00, 1'b1);
    rd(8'h08, 8'h01, 8'h00, 1'b1);
    rd(8'h0a, 8'h01, 8'h00, 1'b1);
    $display("TB: reset test done");
    tally_and_finish();
  end
endmodule // testbench
